// [iosge_alu.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Shared constants, encodings and types
// ==========================================================================
package iosge_pkg;
    // Data path widths.
    localparam int IOSGE_IW = 14;
    localparam int IOSGE_DW = 8;
    localparam int IOSGE_PCW = 15;
    localparam int IOSGE_FAW = 7;
    localparam int IOSGE_LATW = 7;
    localparam int IOSGE_JKW = 11;

    // Instruction word field positions.
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int FADR_MSB = 6;
    localparam int LIT_MSB = 7;
    localparam int JTAG_LSB = 11;
    localparam int JK_MSB = 10;
    localparam int LATH_JMP_MSB = 6;
    localparam int LATH_JMP_LSB = 3;

    // Opcode values of the top six bits, and the jump tag of the top three.
    localparam logic [5:0] OPC_INC_FILE = 6'h0A;
    localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
    localparam logic [5:0] OPC_OR_FILE = 6'h04;
    localparam logic [5:0] OPC_SHL_FILE = 6'h35;
    localparam logic [5:0] OPC_OR_LIT = 6'h38;
    localparam logic [2:0] JTAG_JUMP = 3'h5;

    // Register byte offsets on the bus.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_LATH = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;

    // Field positions and reset values.
    localparam int CTRL_RUN = 0;
    localparam int STAT_Z = 0;
    localparam int STAT_C = 1;
    localparam int STATE_SKIP = 0;
    localparam int STATE_FILL = 1;
    localparam logic CTRL_RST = 1'b1;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [6:0] LATH_RST = 7'h00;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        OPK_NOP,
        OPK_INC_FILE,
        OPK_INC_SKIP,
        OPK_ABSOLUTE_JUMP,
        OPK_OR_LIT,
        OPK_OR_FILE,
        OPK_SHL_FILE
    } iosge_op_e;
endpackage

// ==========================================================================
// Arithmetic and logic unit
// ==========================================================================
module iosge_alu
    import iosge_pkg::*;
(
    input wire iosge_op_e op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] fval_i,
    input wire logic [7:0] lit_i,
    output logic [7:0] res_o,
    output logic carry_o
);
    // Computes the result byte and the shifted-out bit of each operation.
    always_comb begin
        res_o = acc_i;
        carry_o = 1'b0;
        case (op_i)
            OPK_INC_FILE, OPK_INC_SKIP: begin
                res_o = 8'(fval_i + ONE);
            end
            OPK_OR_LIT: begin
                res_o = acc_i | lit_i;
            end
            OPK_OR_FILE: begin
                res_o = acc_i | fval_i;
            end
            OPK_SHL_FILE: begin
                res_o = {fval_i[6:0], 1'b0};
                carry_o = fval_i[7];
            end
            default: begin
                res_o = acc_i;
            end
        endcase
    end
endmodule

`default_nettype wire

// [iosge_exec.sv]
// Contract
// - Destination bit picks accumulator or file
// - Increment-skip adds one, keeps all flags
// - Zero result turns next instruction into nop
// - Plain increment updates zero flag, never skips
// - Jump loads eleven bits into low counter
// - Jump takes upper counter from latch bits
// - Jump takes two cycles, keeps flags
// - Literal OR into accumulator, zero flag
// - Accumulator OR file, routed, zero flag
// - Left shift, bit seven into carry
// - Shift result routed by destination bit
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Execution unit with AHB-Lite register access
// ==========================================================================
module iosge_exec
    import iosge_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    output logic instr_ready_o,
    output logic [14:0] pc_o,
    output logic [6:0] file_addr_o,
    input wire logic [7:0] file_rdata_i,
    output logic file_we_o,
    output logic [7:0] file_wdata_o
);
    typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_FILL} iosge_state_e;

    iosge_state_e state;
    logic [13:0] ir;
    logic discard;
    logic skip_pending;
    logic run;
    logic [7:0] acc;
    logic z_flag;
    logic c_flag;
    logic [6:0] lath;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic bus_wr;
    logic exec;
    iosge_op_e op;
    logic dest_file;
    logic [7:0] alu_res;
    logic alu_carry;
    logic res_zero;
    logic takes_z;
    logic [14:0] pc;

    // Maps an instruction word onto the operation it names.
    function automatic iosge_op_e decode_op(input logic [13:0] w);
        iosge_op_e k;
        k = OPK_NOP;
        if (w[OPC_MSB:JTAG_LSB] == JTAG_JUMP) begin
            k = OPK_ABSOLUTE_JUMP;
        end else begin
            case (w[OPC_MSB:OPC_LSB])
                OPC_INC_FILE: k = OPK_INC_FILE;
                OPC_INC_SKIP: k = OPK_INC_SKIP;
                OPC_OR_FILE: k = OPK_OR_FILE;
                OPC_SHL_FILE: k = OPK_SHL_FILE;
                OPC_OR_LIT: k = OPK_OR_LIT;
                default: k = OPK_NOP;
            endcase
        end
        return k;
    endfunction

    // ======================================================================
    // Decode and datapath
    // ======================================================================
    // The executing instruction, its destination and its effects.
    assign exec = (state == ST_EXEC) && !discard;
    assign op = decode_op(ir);
    assign dest_file = ir[DEST_BIT];
    assign file_addr_o = ir[FADR_MSB:0];
    assign res_zero = (alu_res == 8'h00);
    assign takes_z = (op == OPK_INC_FILE) || (op == OPK_OR_LIT) ||
                     (op == OPK_OR_FILE) || (op == OPK_SHL_FILE);
    assign instr_ready_o = run && (state == ST_FETCH);
    assign pc_o = pc;

    iosge_alu u_alu (
        .op_i(op),
        .acc_i(acc),
        .fval_i(file_rdata_i),
        .lit_i(ir[LIT_MSB:0]),
        .res_o(alu_res),
        .carry_o(alu_carry)
    );

    // ======================================================================
    // Sequencing
    // ======================================================================
    // Fetch takes a word, exec runs it, fill is the jump's second cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_FETCH;
        end else begin
            case (state)
                ST_FETCH: begin
                    if (instr_valid_i && instr_ready_o) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (exec && op == OPK_ABSOLUTE_JUMP) begin
                        state <= ST_FILL;
                    end else begin
                        state <= ST_FETCH;
                    end
                end
                ST_FILL: state <= ST_FETCH;
                default: state <= ST_FETCH;
            endcase
        end
    end

    // Latches the fetched word and whether it stands in for a nop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir <= 14'h0000;
            discard <= 1'b0;
        end else if (instr_valid_i && instr_ready_o) begin
            ir <= instr_i;
            discard <= skip_pending;
        end
    end

    // A zero increment-skip result arms the nop for the next word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_pending <= 1'b0;
        end else if (exec && op == OPK_INC_SKIP) begin
            skip_pending <= res_zero;
        end else if (instr_valid_i && instr_ready_o) begin
            skip_pending <= 1'b0;
        end
    end

    // Program counter: jump load wins over a bus write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= PC_RST;
        end else if (exec && op == OPK_ABSOLUTE_JUMP) begin
            pc <= {lath[LATH_JMP_MSB:LATH_JMP_LSB], ir[JK_MSB:0]};
        end else if (state == ST_EXEC) begin
            pc <= 15'(pc + 15'h0001);
        end else if (bus_wr && ph_addr == REG_PC) begin
            pc <= hwdata_i[IOSGE_PCW-1:0];
        end
    end

    // Accumulator: results with destination zero win over a bus write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= ACC_RST;
        end else if (exec && op == OPK_OR_LIT) begin
            acc <= alu_res;
        end else if (exec && op != OPK_NOP && op != OPK_ABSOLUTE_JUMP && !dest_file) begin
            acc <= alu_res;
        end else if (bus_wr && ph_addr == REG_ACC) begin
            acc <= hwdata_i[IOSGE_DW-1:0];
        end
    end

    // Zero and carry flags: only the documented operations and a bus write to the status register touch them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            z_flag <= STATUS_RST[STAT_Z];
            c_flag <= STATUS_RST[STAT_C];
        end else if (exec && takes_z) begin
            z_flag <= res_zero;
            if (op == OPK_SHL_FILE) begin
                c_flag <= alu_carry;
            end
        end else if (bus_wr && ph_addr == REG_STATUS) begin
            z_flag <= hwdata_i[STAT_Z];
            c_flag <= hwdata_i[STAT_C];
        end
    end

    // File write-back, issued one cycle after exec from flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            file_we_o <= 1'b0;
            file_wdata_o <= 8'h00;
        end else begin
            file_we_o <= exec && dest_file && op != OPK_NOP &&
                         op != OPK_ABSOLUTE_JUMP && op != OPK_OR_LIT;
            file_wdata_o <= alu_res;
        end
    end

    // ======================================================================
    // AHB-Lite slave
    // ======================================================================
    // Zero wait states, always OKAY; the data phase follows the address.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign bus_wr = ph_valid && ph_write;

    // Captures the address phase of a selected transfer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end else if (hready_i) begin
            ph_valid <= hsel_i && htrans_i[1];
            ph_write <= hwrite_i;
            ph_addr <= haddr_i[7:0];
        end
    end

    // Read data is registered at the address phase; unmapped reads zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i[7:0])
                REG_CTRL: hrdata_o <= {31'h0, run};
                REG_ACC: hrdata_o <= {24'h0, acc};
                REG_STATUS: hrdata_o <= {30'h0, c_flag, z_flag};
                REG_PC: hrdata_o <= {17'h0, pc};
                REG_LATH: hrdata_o <= {25'h0, lath};
                REG_STATE: hrdata_o <= {30'h0, state == ST_FILL,
                                        skip_pending};
                default: hrdata_o <= 32'h00000000;
            endcase
        end
    end

    // Control and latch registers written by software.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run <= CTRL_RST;
            lath <= LATH_RST;
        end else if (bus_wr) begin
            if (ph_addr == REG_CTRL) begin
                run <= hwdata_i[CTRL_RUN];
            end
            if (ph_addr == REG_LATH) begin
                lath <= hwdata_i[IOSGE_LATW-1:0];
            end
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    logic [7:0] exp_jump_lo;
    assign exp_jump_lo = 8'(ir[JK_MSB:0]);

    sequence s_fill_then_fetch;
        state == ST_FILL ##1 state == ST_FETCH;
    endsequence

    sequence s_exec_op(iosge_op_e k);
        exec && op == k;
    endsequence

    property p_skip_arm;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_INC_SKIP) ##0 res_zero |=> skip_pending;
    endproperty
    a_skip_arm: assert property (p_skip_arm)
        else $error("zero increment-skip did not arm the nop");

    property p_skip_nop;
        @(posedge clk_i) disable iff (rst_i)
        skip_pending && instr_valid_i && instr_ready_o |=>
            !exec ##1 !file_we_o && !skip_pending;
    endproperty
    a_skip_nop: assert property (p_skip_nop)
        else $error("skipped instruction was executed");

    property p_skip_flags;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_INC_SKIP) |=> $stable(z_flag) && $stable(c_flag);
    endproperty
    a_skip_flags: assert property (p_skip_flags)
        else $error("increment-skip changed a flag");

    property p_inc_noskip;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_INC_FILE) |=> !skip_pending &&
            z_flag == ($past(file_rdata_i) == 8'hFF);
    endproperty
    a_inc_noskip: assert property (p_inc_noskip)
        else $error("increment skipped or set zero wrongly");

    property p_jump_pc;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_ABSOLUTE_JUMP) |=>
            pc[JK_MSB:0] == $past(ir[JK_MSB:0]) &&
            pc[14:11] == $past(lath[LATH_JMP_MSB:LATH_JMP_LSB]);
    endproperty
    a_jump_pc: assert property (p_jump_pc)
        else $error("jump loaded the wrong counter value");

    property p_jump_two;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_ABSOLUTE_JUMP) |=> s_fill_then_fetch ##0 $stable(z_flag);
    endproperty
    a_jump_two: assert property (p_jump_two)
        else $error("jump did not take two cycles");

    property p_or_literal;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_OR_LIT) |=>
            acc == ($past(acc) | $past(ir[LIT_MSB:0])) &&
            z_flag == (acc == 8'h00);
    endproperty
    a_or_literal: assert property (p_or_literal)
        else $error("literal OR gave a wrong accumulator");

    property p_or_file;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_OR_FILE) && dest_file |=> file_we_o &&
            file_wdata_o == ($past(acc) | $past(file_rdata_i)) &&
            z_flag == (file_wdata_o == 8'h00);
    endproperty
    a_or_file: assert property (p_or_file)
        else $error("file OR wrote a wrong value");

    property p_shift;
        @(posedge clk_i) disable iff (rst_i)
        s_exec_op(OPK_SHL_FILE) && !dest_file |=>
            c_flag == $past(file_rdata_i[7]) &&
            acc == {$past(file_rdata_i[6:0]), 1'b0} && !file_we_o;
    endproperty
    a_shift: assert property (p_shift)
        else $error("left shift gave wrong result or carry");

    property p_one_cycle;
        @(posedge clk_i) disable iff (rst_i)
        state == ST_EXEC && !(exec && op == OPK_ABSOLUTE_JUMP) |=>
            state == ST_FETCH && pc == 15'($past(pc) + 15'h0001);
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("instruction did not finish in one cycle");

    logic unused_ok;
    assign unused_ok = ^{hsize_i, hwdata_i[31:16], haddr_i[31:8],
                         exp_jump_lo};
endmodule

`default_nettype wire

// [iosge_file_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Data file space seen by the execution unit
// ==========================================================================
module iosge_file_model (
    input wire logic clk_i,
    input wire logic [6:0] addr_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [128];

    // Reads are combinational, since the unit samples them in one cycle.
    assign rdata_o = mem[addr_i];

    // A write pulse stores the byte at the rising edge.
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// [tb_inc_or_shift_absolute_jump_exec.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Self-checking bench for the execution unit
// ==========================================================================
module tb_inc_or_shift_absolute_jump_exec
    import iosge_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr = 14'h0;
    logic hready, hresp, instr_ready, file_we;
    logic [31:0] hrdata;
    logic [14:0] pc_out;
    logic [6:0] file_addr;
    logic [7:0] file_rdata, file_wdata;
    int acc = 0, z = 0, c = 0, pc = 0, lath = 0, skip = 0;
    int em [128];
    int mismatches = 0;
    int total_checks = 0;
    logic [5:0] ops [5] = '{OPC_INC_FILE, OPC_INC_SKIP, OPC_OR_FILE,
                            OPC_SHL_FILE, OPC_OR_LIT};
    // Zero literal OR, zero skip, discarded jump, shift to zero, then plain cases.
    logic [13:0] dir_words [8] = '{{OPC_OR_LIT, 8'h00},
        {OPC_INC_SKIP, 8'h85}, {JTAG_JUMP, 11'h7FF}, {OPC_SHL_FILE, 8'h86},
        {OPC_INC_FILE, 8'h06}, {OPC_OR_FILE, 8'h87}, {OPC_INC_SKIP, 8'h07},
        {JTAG_JUMP, 11'h7FF}};

    iosge_exec uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hsel_i(1'b1),
        .haddr_i(haddr),
        .htrans_i(htrans),
        .hwrite_i(hwrite),
        .hsize_i(3'h2),
        .hwdata_i(hwdata),
        .hready_i(hready),
        .hreadyout_o(hready),
        .hresp_o(hresp),
        .hrdata_o(hrdata),
        .instr_valid_i(instr_valid),
        .instr_i(instr),
        .instr_ready_o(instr_ready),
        .pc_o(pc_out),
        .file_addr_o(file_addr),
        .file_rdata_i(file_rdata),
        .file_we_o(file_we),
        .file_wdata_o(file_wdata)
    );

    iosge_file_model u_mem (
        .clk_i(clk_i),
        .addr_i(file_addr),
        .we_i(file_we),
        .wdata_i(file_wdata),
        .rdata_o(file_rdata)
    );

    // The clock toggles every half period of 5 ns.
    always #5 clk_i = ~clk_i;

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One single-word transfer; entered just after a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // Sets one file byte in both the model and the file space.
    task automatic poke(input int a, input int v);
        em[a] = v;
        u_mem.mem[a] = 8'(v);
    endtask

    // Reference behaviour of one accepted word.
    task automatic predict(input logic [13:0] w, output logic we,
                           output logic fill);
        int v;
        int r;
        v = em[w[6:0]];
        r = -1;
        we = 1'b0;
        fill = 1'b0;
        pc = (pc + 1) & 32'h7FFF;
        if (skip != 0) begin
            skip = 0;
        end else if (w[13:11] == JTAG_JUMP) begin
            pc = (((lath >> 3) & 15) << 11) | int'(w[10:0]);
            fill = 1'b1;
        end else begin
            case (w[13:8])
                OPC_INC_FILE: r = (v + 1) & 255;
                OPC_INC_SKIP: r = (v + 1) & 255;
                OPC_OR_FILE: r = acc | v;
                OPC_SHL_FILE: r = (v << 1) & 255;
                OPC_OR_LIT: acc = acc | int'(w[7:0]);
                default: r = -1;
            endcase
            if (w[13:8] == OPC_SHL_FILE) begin
                c = v >> 7;
            end
            if (w[13:8] == OPC_INC_SKIP) begin
                skip = int'(r == 0);
            end else if (w[13:8] == OPC_OR_LIT) begin
                z = int'(acc == 0);
            end else if (r >= 0) begin
                z = int'(r == 0);
            end
        end
        if (r >= 0 && w[7]) begin
            em[w[6:0]] = r;
            we = 1'b1;
        end else if (r >= 0) begin
            acc = r;
        end
    endtask

    // Offers one word, follows its cycles and compares all results.
    task automatic run(input logic [13:0] w);
        logic we;
        logic fill;
        logic [31:0] rd;
        predict(w, we, fill);
        instr_valid <= 1'b1;
        instr <= w;
        @(negedge clk_i);
        while (instr_ready !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        instr_valid <= 1'b0;
        @(negedge clk_i);
        check(32'(instr_ready), 32'h0);
        @(negedge clk_i);
        check(32'(pc_out), 32'(pc));
        check(32'(instr_ready), 32'(!fill));
        check(32'(file_we), 32'(we));
        check(32'(hresp), 32'h0);
        @(posedge clk_i);
        bus(1'b0, REG_ACC, 32'h0, rd);
        check(rd, 32'(acc));
        bus(1'b0, REG_STATUS, 32'h0, rd);
        check(rd, 32'(z | (c << STAT_C)));
        bus(1'b0, REG_STATE, 32'h0, rd);
        check(rd, 32'(skip));
        check(32'(u_mem.mem[w[6:0]]), 32'(em[w[6:0]]));
    endtask

    // Main sequence: reset values, refusal, directed and random words.
    initial begin
        logic [31:0] rd;
        int k;
        void'($urandom(32'h3CA1A9CA));
        for (int i = 0; i < 128; i++) begin
            poke(i, $urandom_range(255));
        end
        poke(5, 255);
        poke(6, 128);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0, rd);
            check(rd, (i == 0) ? 32'h1 : 32'h0);
        end
        bus(1'b1, REG_CTRL, 32'h0, rd);
        @(posedge clk_i);
        check(32'(instr_ready), 32'h0);
        bus(1'b1, REG_CTRL, 32'h1, rd);
        lath = 32'h50;
        bus(1'b1, REG_LATH, 32'(lath), rd);
        foreach (dir_words[i]) begin
            run(dir_words[i]);
        end
        for (int n = 0; n < 80; n++) begin
            if (n % 8 == 0) begin
                lath = $urandom_range(127);
                bus(1'b1, REG_LATH, 32'(lath), rd);
            end
            k = $urandom_range(5);
            rd = $urandom;
            run((k == 5) ? {JTAG_JUMP, rd[10:0]} : {ops[k], rd[7:0]});
        end
        conclude();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
